// ==== rtl/nvsram_defines.svh ====
/*
  Constants of the serial nonvolatile SRAM command slave: opcodes, address
  layout, block protection bounds and nonvolatile cycle timing.
  Assumes a 250 MHz system clock; included by bare name from rtl/.
*/
// Notes on behaviour
// - No read or write during save or recall.
// - Save shows busy on status bit and pin.
// - First address byte bit 0 is top bit.
// - Read data shifts out MSB first, falling SCK.
// - Read burst increments address after each byte.
// - Address wraps from top to zero.
// - Write is opcode, three address bytes, data.
// - Write burst stores bytes at incrementing addresses.
// - Completed write clears the write enable latch.
// - Protected block writes discarded, address still advances.
// - Decode save and recall opcodes.
// - Decode autosave on and off opcodes.
// - Save command starts a save cycle only with latch set and not busy.
// - Special opcode needs latch; cleared at select release.
// - Autosave enabled by default; setting is volatile.
// - Without autosave, on/off only report busy.
// - Hold pauses and resumes with SCK low.
// - Paused: ignore input, output high impedance.
// - Status ready bit set during save or recall.
// - Write enable command sets latch; cleared at reset.
// - Latch clear: write instructions ignored.
`ifndef NVSRAM_DEFINES_SVH
`define NVSRAM_DEFINES_SVH

// Opcodes of the instruction set
`define OP_READ              8'h03
`define OP_WRITE             8'h02
`define SET_WRITE_ENABLE_CMD 8'h06
`define OP_SAVE              8'h3C
`define OP_RECALL            8'h60
`define AUTOSAVE_ON_CMD      8'h59
`define AUTOSAVE_OFF_CMD     8'h19

// Address space and protection bounds
`define ADDR_W         17
`define ADDR_TOP       17'h1FFFF
`define MEM_DEPTH      131072
`define PROT_QUARTER   17'h18000
`define PROT_HALF      17'h10000
`define FIFO_DEPTH     16
`define FIFO_WIDTH     25

// Nonvolatile cycle timing
`define CLK_PERIOD_NS  4
`define T_SAVE_NS      8000
`define T_RECALL_NS    2000
`define T_SS_NS        1000
`define SAVE_CYCLES    ((`T_SAVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECALL_CYCLES  ((`T_RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SS_CYCLES      ((`T_SS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_CNT_W     16

`endif

// ==== rtl/nvsram_pkg.sv ====
/*
  Types of the serial nonvolatile SRAM command slave.
  Assumes nothing beyond the defines header.
*/
package nvsram_pkg;

  // Serial sequence phases
  typedef enum logic [2:0] {
    ST_OPCODE  = 3'b000,
    ST_ADDR    = 3'b001,
    ST_RD_DATA = 3'b010,
    ST_WR_DATA = 3'b011,
    ST_IGNORE  = 3'b100
  } seq_state_t;

  // Nonvolatile operation awaiting select release
  typedef enum logic [2:0] {
    NV_NONE   = 3'b000,
    NV_SAVE   = 3'b001,
    NV_RECALL = 3'b010,
    NV_AS_ON  = 3'b011,
    NV_AS_OFF = 3'b100
  } nv_op_t;

endpackage : nvsram_pkg

// ==== rtl/spi_nv_sram_command_slave.sv ====
/*
  SPI slave command logic of a 128K x 8 nonvolatile SRAM: read and write
  bursts, write enable latch, block protection, save, recall, autosave
  control and HOLD pausing. Holds the SRAM array and a write FIFO.
  Assumes SCK, chip select, serial input and hold arrive asynchronously
  and are much slower than clk_sys (SCK half period of at least 4 cycles).
*/
`timescale 1ns/100ps
`include "nvsram_defines.svh"

// Two flip-flop synchroniser with per-bit reset value
module sync2 #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // Second stage is the only reader of the first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule : sync2

// Synchronous FIFO with valid and ready on both sides
module wr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // Pointer and fill level update
  always_comb begin
    push    = in_valid && (cnt_r < (AW + 1)'(D));
    pop     = out_valid && out_ready;
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  assign in_ready  = (cnt_r < (AW + 1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
endmodule : wr_fifo

// Command slave top
module spi_nv_sram_command_slave #(
  parameter bit          AUTOSAVE_SUPPORTED = 1'b1,
  parameter int unsigned SAVE_CYCLES        = `SAVE_CYCLES,
  parameter int unsigned RECALL_CYCLES      = `RECALL_CYCLES,
  parameter int unsigned SS_CYCLES          = `SS_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic [1:0] block_protect,
  output logic            so,
  output logic            so_oe_n,
  output logic            ready_busy,
  output logic            hw_store_busy_pin_n,
  output logic            write_enable,
  output logic            autosave_enable
);
  import nvsram_pkg::*;

  localparam int unsigned AW = `ADDR_W;

  logic [7:0]  mem [`MEM_DEPTH];
  logic [3:0]  pin_s;
  logic        sck_s, cs_s, si_s, hold_s;
  logic        sck_rise, sck_fall, cs_rise;
  logic        sck_d_r, cs_d_r;

  seq_state_t  state_r, state_nxt;
  nv_op_t      nv_pend_r, nv_pend_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [1:0]  abyte_r, abyte_nxt;
  logic [7:0]  shin_r, shin_nxt, rdb_r, rdb_nxt, rx_byte, mem_q;
  logic [AW-1:0] addr_r, addr_nxt;
  logic        so_r, so_nxt, oe_n_r, oe_n_nxt, drv_r, drv_nxt;
  logic        wen_r, wen_nxt, wclr_r, wclr_nxt, paused_r, paused_nxt;
  logic        wpend_r, wpend_nxt;
  logic [`FIFO_WIDTH-1:0] wword_r, wword_nxt, fifo_q;
  logic        fifo_in_ready, fifo_out_valid, fifo_out_ready;

  logic [`BUSY_CNT_W-1:0] bcnt_r, bcnt_nxt;
  logic        bsave_r, bsave_nxt, rdy_r, rdy_nxt, hsb_n_r, hsb_n_nxt;
  logic        as_r, as_nxt;

  // Link pins pass two flip-flops before use; reset to idle levels (clock low, deselected, hold released)
  sync2 #(.W(4), .RST_VAL(4'h5)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({sck, cs_n, si, hold_n}),
    .q       (pin_s)
  );

  assign sck_s    = pin_s[3];
  assign cs_s     = pin_s[2];
  assign si_s     = pin_s[1];
  assign hold_s   = pin_s[0];
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cs_rise  = cs_s & ~cs_d_r & ~paused_r;
  assign rx_byte  = {shin_r[6:0], si_s};
  assign mem_q    = mem[addr_r];

  // Address inside the protected block set by the protect level
  function automatic logic is_protected(input logic [1:0] lvl, input logic [AW-1:0] a);
    case (lvl)
      2'b00:   is_protected = 1'b0;
      2'b01:   is_protected = (a >= `PROT_QUARTER);
      2'b10:   is_protected = (a >= `PROT_HALF);
      default: is_protected = 1'b1;
    endcase
  endfunction : is_protected

  // Serial sequence, write enable latch and hold pause
  always_comb begin
    state_nxt   = state_r;
    nv_pend_nxt = nv_pend_r;
    bit_nxt     = bit_r;
    abyte_nxt   = abyte_r;
    shin_nxt    = shin_r;
    rdb_nxt     = rdb_r;
    addr_nxt    = addr_r;
    so_nxt      = so_r;
    drv_nxt     = drv_r;
    wen_nxt     = wen_r;
    wclr_nxt    = wclr_r;
    paused_nxt  = paused_r;
    wpend_nxt   = wpend_r && !fifo_in_ready;
    wword_nxt   = wword_r;
    // Pause and resume only while SCK is low
    if (!sck_s && !cs_s) begin
      paused_nxt = !hold_s;
    end
    if (cs_s) begin
      if (!paused_r) begin
        // Select release ends the instruction
        if (wclr_r) begin
          wen_nxt = 1'b0;
        end
        state_nxt   = ST_OPCODE;
        nv_pend_nxt = NV_NONE;
        bit_nxt     = 3'd0;
        abyte_nxt   = 2'd0;
        wclr_nxt    = 1'b0;
        drv_nxt     = 1'b0;
      end
    end else if (!paused_r) begin
      if (sck_rise && state_r != ST_RD_DATA && state_r != ST_IGNORE) begin
        shin_nxt = rx_byte;
        bit_nxt  = bit_r + 3'd1;
        if (bit_r == 3'd7) begin
          case (state_r)
            ST_OPCODE: begin
              state_nxt = ST_IGNORE;
              case (rx_byte)
                `OP_READ: begin
                  if (rdy_r == 1'b0) begin
                    state_nxt = ST_ADDR;
                  end
                end
                `OP_WRITE: begin
                  if (!rdy_r && wen_r) begin
                    state_nxt = ST_ADDR;
                    wclr_nxt  = 1'b1;
                  end
                end
                `SET_WRITE_ENABLE_CMD: begin
                  wen_nxt = 1'b1;
                end
                `OP_SAVE, `OP_RECALL, `AUTOSAVE_ON_CMD, `AUTOSAVE_OFF_CMD: begin
                  if (wen_r && !rdy_r) begin
                    wclr_nxt = 1'b1;
                    case (rx_byte)
                      `OP_SAVE:        nv_pend_nxt = NV_SAVE;
                      `OP_RECALL:      nv_pend_nxt = NV_RECALL;
                      `AUTOSAVE_ON_CMD: nv_pend_nxt = NV_AS_ON;
                      default:         nv_pend_nxt = NV_AS_OFF;
                    endcase
                  end
                end
                default: state_nxt = ST_IGNORE;
              endcase
              if (rx_byte == `OP_READ) begin
                wword_nxt[`FIFO_WIDTH-1] = wword_r[`FIFO_WIDTH-1];
              end
              drv_nxt = (rx_byte == `OP_READ) ? 1'b0 : drv_r;
              rdb_nxt = {7'h00, rx_byte == `OP_READ};         // Remembers read or write
            end
            ST_ADDR: begin
              // Top address bit in bit 0 of first byte
              case (abyte_r)
                2'd0:    addr_nxt = {rx_byte[0], addr_r[15:0]};
                2'd1:    addr_nxt = {addr_r[16], rx_byte, addr_r[7:0]};
                default: addr_nxt = {addr_r[16:8], rx_byte};
              endcase
              abyte_nxt = abyte_r + 2'd1;
              if (abyte_r == 2'd2) begin
                state_nxt = rdb_r[0] ? ST_RD_DATA : ST_WR_DATA;
              end
            end
            ST_WR_DATA: begin
              // Unprotected bytes go to the FIFO
              if (!is_protected(block_protect, addr_r)) begin
                wpend_nxt = 1'b1;
                wword_nxt = {addr_r, rx_byte};
              end
              addr_nxt = addr_r + AW'(1);
            end
            default: state_nxt = state_r;
          endcase
        end
      end
      // Read data shifts out on falling SCK
      if (sck_fall && state_r == ST_RD_DATA) begin
        drv_nxt = 1'b1;
        bit_nxt = bit_r + 3'd1;
        if (bit_r == 3'd0) begin
          rdb_nxt = mem_q;
          so_nxt  = mem_q[7];
        end else begin
          so_nxt = rdb_r[3'd7 - bit_r];
        end
        if (bit_r == 3'd7) begin
          addr_nxt = addr_r + AW'(1);
        end
      end
    end
    oe_n_nxt = ~(drv_nxt & ~cs_s & ~paused_nxt);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_OPCODE;
      nv_pend_r <= NV_NONE;
      bit_r     <= 3'd0;
      abyte_r   <= 2'd0;
      shin_r    <= 8'h00;
      rdb_r     <= 8'h00;
      addr_r    <= '0;
      so_r      <= 1'b0;
      oe_n_r    <= 1'b1;
      drv_r     <= 1'b0;
      wen_r     <= 1'b0;
      wclr_r    <= 1'b0;
      paused_r  <= 1'b0;
      wpend_r   <= 1'b0;
      wword_r   <= '0;
      sck_d_r   <= 1'b0;
      cs_d_r    <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      nv_pend_r <= nv_pend_nxt;
      bit_r     <= bit_nxt;
      abyte_r   <= abyte_nxt;
      shin_r    <= shin_nxt;
      rdb_r     <= rdb_nxt;
      addr_r    <= addr_nxt;
      so_r      <= so_nxt;
      oe_n_r    <= oe_n_nxt;
      drv_r     <= drv_nxt;
      wen_r     <= wen_nxt;
      wclr_r    <= wclr_nxt;
      paused_r  <= paused_nxt;
      wpend_r   <= wpend_nxt;
      wword_r   <= wword_nxt;
      sck_d_r   <= sck_s;
      cs_d_r    <= cs_s;
    end
  end

  // Nonvolatile cycles start at select release
  always_comb begin
    bcnt_nxt  = (bcnt_r != '0) ? bcnt_r - 1'b1 : bcnt_r;
    bsave_nxt = bsave_r && (bcnt_nxt != '0);
    as_nxt    = as_r;
    if (cs_rise) begin
      case (nv_pend_r)
        NV_SAVE: begin
          bcnt_nxt  = `BUSY_CNT_W'(SAVE_CYCLES);
          bsave_nxt = 1'b1;
        end
        NV_RECALL: bcnt_nxt = `BUSY_CNT_W'(RECALL_CYCLES);
        NV_AS_ON, NV_AS_OFF: begin
          bcnt_nxt = `BUSY_CNT_W'(SS_CYCLES);
          if (AUTOSAVE_SUPPORTED) begin
            as_nxt = (nv_pend_r == NV_AS_ON);
          end
        end
        default: bcnt_nxt = bcnt_nxt;
      endcase
    end
    rdy_nxt   = (bcnt_nxt != '0);
    hsb_n_nxt = ~bsave_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r  <= '0;
      bsave_r <= 1'b0;
      rdy_r   <= 1'b0;
      hsb_n_r <= 1'b1;
      as_r    <= AUTOSAVE_SUPPORTED;
    end else begin
      bcnt_r  <= bcnt_nxt;
      bsave_r <= bsave_nxt;
      rdy_r   <= rdy_nxt;
      hsb_n_r <= hsb_n_nxt;
      as_r    <= as_nxt;
    end
  end

  // Write bytes queue up; the array is not written during a cycle
  wr_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (wpend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (wword_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_q)
  );

  assign fifo_out_ready = ~rdy_r;

  always_ff @(posedge clk_sys) begin
    if (fifo_out_valid && fifo_out_ready) begin
      mem[fifo_q[`FIFO_WIDTH-1:8]] <= fifo_q[7:0];
    end
  end

  assign so                  = so_r;
  assign so_oe_n             = oe_n_r;
  assign ready_busy          = rdy_r;
  assign hw_store_busy_pin_n = hsb_n_r;
  assign write_enable        = wen_r;
  assign autosave_enable     = as_r;
endmodule : spi_nv_sram_command_slave

// ==== testbench/spi_nv_sram_command_slave_props.sv ====
/*
  Checker of the serial nvSRAM command slave, bound to the top module.
  Assumes it sees only the top ports and the nonvolatile cycle counts.
*/
`timescale 1ns/100ps
module spi_nv_sram_command_slave_props #(
  parameter int unsigned SAVE_CYCLES   = 20,
  parameter int unsigned RECALL_CYCLES = 20,
  parameter int unsigned SS_CYCLES     = 20
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       si,
  input wire logic       hold_n,
  input wire logic [1:0] block_protect,
  input wire logic       so,
  input wire logic       so_oe_n,
  input wire logic       ready_busy,
  input wire logic       hw_store_busy_pin_n,
  input wire logic       write_enable,
  input wire logic       autosave_enable
);
  logic [15:0] busy_len_r;
  logic [15:0] busy_len_nxt;

  // Length of the current busy stretch
  always_comb begin
    busy_len_nxt = ready_busy ? busy_len_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_r <= 16'h0000;
    end else begin
      busy_len_r <= busy_len_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Steps of a special instruction
  sequence cs_release;
    $rose(cs_n);
  endsequence
  sequence busy_start;
    $rose(ready_busy);
  endsequence

  chk_store_pin_busy: assert property (!hw_store_busy_pin_n |-> ready_busy)
    else $error("store pin low while status shows ready");
  chk_busy_len_exact: assert property ($fell(ready_busy) |->
    (busy_len_r == SAVE_CYCLES || busy_len_r == RECALL_CYCLES || busy_len_r == SS_CYCLES))
    else $error("busy stretch of wrong length");
  chk_save_pin_hold: assert property ($fell(hw_store_busy_pin_n) |-> !hw_store_busy_pin_n [*8])
    else $error("store pin pulse too short");
  chk_busy_after_cs: assert property (busy_start |-> cs_n)
    else $error("nonvolatile cycle began while selected");
  chk_busy_clears_wel: assert property (busy_start |-> ##[0:4] !write_enable)
    else $error("latch not cleared by special instruction");
  chk_oe_after_cs: assert property (cs_release |-> ##[0:6] so_oe_n)
    else $error("output still driven after deselect");
  chk_hold_hiz: assert property ($fell(hold_n) && !sck && !cs_n |-> ##[0:6] so_oe_n)
    else $error("output driven while paused");
  chk_autosave_busy: assert property ($changed(autosave_enable) |-> ##[0:2] ready_busy)
    else $error("autosave changed without busy cycle");
  chk_wel_in_frame: assert property ($rose(write_enable) |-> !cs_n)
    else $error("latch set outside a frame");
endmodule : spi_nv_sram_command_slave_props

bind spi_nv_sram_command_slave spi_nv_sram_command_slave_props #(
  .SAVE_CYCLES(SAVE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES), .SS_CYCLES(SS_CYCLES)
) props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
  .block_protect(block_protect), .so(so), .so_oe_n(so_oe_n), .ready_busy(ready_busy),
  .hw_store_busy_pin_n(hw_store_busy_pin_n), .write_enable(write_enable), .autosave_enable(autosave_enable)
);

// ==== testbench/spi_master_model.sv ====
/*
  SPI master in mode 0 that drives the command slave; tasks are called from the bench.
  Assumes a 4 ns clk_sys; SCK runs only inside frames at 32 ns a period.
*/
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic clk_sys,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n
);
  logic last_so;

  // Idle bus: deselected, clock low
  initial begin
    sck     = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
    hold_n  = 1'b1;
    last_so = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_clk

  // Select or release the slave, with clock held low
  task automatic select(input logic on);
    wait_clk(8);
    cs_n = !on;
    wait_clk(on ? 4 : 12);
  endtask : select

  // One byte each way, MSB first; a released output reads as the inverse of its last level
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      if (!so_oe_n) begin
        last_so = so;
      end
      rx[i] = so_oe_n ? !last_so : so;
      sck = 1'b0;
    end
  endtask : xfer

  // Pause with SCK low, then toggle junk on the bus
  task automatic hold_pause(input logic [7:0] junk);
    hold_n = 1'b0;
    wait_clk(4);
    for (int i = 0; i < 4; i++) begin
      si  = junk[i];
      sck = 1'b1;
      wait_clk(4);
      sck = 1'b0;
      wait_clk(4);
    end
  endtask : hold_pause

  task automatic hold_resume();
    hold_n = 1'b1;
    wait_clk(4);
  endtask : hold_resume
endmodule : spi_master_model

// ==== testbench/tb_spi_nv_sram_command_slave.sv ====
/*
  Self-checking bench of the serial nvSRAM command slave with a mode 0 master model.
  Assumes the design's default nonvolatile cycle counts.
*/
`timescale 1ns/100ps
`include "nvsram_defines.svh"
module tb_spi_nv_sram_command_slave;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] block_protect = 2'h0;
  logic       sck, cs_n, si, hold_n, so, so_oe_n;
  logic       ready_busy, hw_store_busy_pin_n, write_enable, autosave_enable;
  logic [7:0] seed_r = 8'h3C;
  logic [7:0] rx;
  logic [7:0] tmp;
  logic [7:0] d [0:3];
  int         n_errors = 0;
  int         n_compared = 0;

  always #2 clk_sys = ~clk_sys;

  spi_nv_sram_command_slave dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .block_protect(block_protect), .so(so), .so_oe_n(so_oe_n), .ready_busy(ready_busy),
    .hw_store_busy_pin_n(hw_store_busy_pin_n), .write_enable(write_enable), .autosave_enable(autosave_enable));
  spi_master_model m (.clk_sys(clk_sys), .so(so), .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n));

  // Random byte source, shift register seeded at 60
  function automatic logic [7:0] rnd();
    seed_r = {seed_r[6:0], seed_r[7] ^ seed_r[5] ^ seed_r[4] ^ seed_r[3]};
    return seed_r;
  endfunction : rnd
  function automatic logic [16:0] wrap(input logic [16:0] a, input int k);
    return a + k[16:0];
  endfunction : wrap
  function automatic logic prot(input logic [1:0] lvl, input logic [16:0] a);
    return (lvl == 2'h3) || (lvl == 2'h2 && a >= 17'h10000) || (lvl == 2'h1 && a >= 17'h18000);
  endfunction : prot

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Opcode then three address bytes, junk in the unused top bits
  task automatic start_cmd(input logic [7:0] op, input logic [16:0] a);
    m.select(1'b1);
    m.xfer(op, rx);
    tmp = rnd();
    m.xfer({tmp[7:1], a[16]}, rx);
    m.xfer(a[15:8], rx);
    m.xfer(a[7:0], rx);
  endtask : start_cmd
  task automatic frame_cmd(input logic [7:0] op);
    m.select(1'b1);
    m.xfer(op, rx);
    m.select(1'b0);
  endtask : frame_cmd
  task automatic write_burst(input logic [16:0] a, input int n, input logic [7:0] flip);
    start_cmd(`OP_WRITE, a);
    for (int k = 0; k < n; k++) begin
      m.xfer(d[k] ^ flip, rx);
    end
    m.select(1'b0);
  endtask : write_burst
  // Read back; bytes the write could store carry the flip
  task automatic read_check(input logic [16:0] a, input int n, input logic [7:0] flip, input logic [1:0] lvl);
    start_cmd(`OP_READ, a);
    for (int k = 0; k < n; k++) begin
      m.xfer(rnd(), rx);
      check_byte("read data", prot(lvl, wrap(a, k)) ? d[k] : d[k] ^ flip, rx);
    end
    m.select(1'b0);
  endtask : read_check
  task automatic wait_idle();
    for (int i = 0; i < 2 * `SAVE_CYCLES && ready_busy !== 1'b0; i++) begin
      @(negedge clk_sys);
    end
    check_bit("ready_busy idle", 1'b0, ready_busy);
    check_bit("store pin idle", 1'b1, hw_store_busy_pin_n);
  endtask : wait_idle
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    m.wait_clk(4);
    check_bit("latch at reset", 1'b0, write_enable);
    check_bit("autosave at reset", 1'b1, autosave_enable);
    for (int k = 0; k < 4; k++) begin
      d[k] = rnd();
    end
    frame_cmd(`SET_WRITE_ENABLE_CMD);
    check_bit("latch set", 1'b1, write_enable);
    write_burst(17'h1FFFE, 3, 8'h00);
    check_bit("latch after write", 1'b0, write_enable);
    read_check(17'h1FFFE, 3, 8'h00, 2'h0);
    write_burst(17'h1FFFE, 3, 8'hFF);
    read_check(17'h1FFFE, 3, 8'hFF, 2'h3);
    $display("test data paths done");
    // Protected burst from below the block and from its top
    for (int s = 0; s < 2; s++) begin
      frame_cmd(`SET_WRITE_ENABLE_CMD);
      write_burst(s ? 17'h1FFFF : 17'h17FFE, 4, 8'h00);
      block_protect = 2'h1;
      frame_cmd(`SET_WRITE_ENABLE_CMD);
      write_burst(s ? 17'h1FFFF : 17'h17FFE, 4, 8'hFF);
      read_check(s ? 17'h1FFFF : 17'h17FFE, 4, 8'hFF, 2'h1);
      block_protect = 2'h0;
    end
    read_check(17'h1FFFF, 1, 8'hFF, 2'h1);
    $display("test protection done");
    // Read with a pause between bytes
    start_cmd(`OP_READ, 17'h17FFE);
    m.xfer(rnd(), rx);
    check_byte("read before hold", d[0] ^ 8'hFF, rx);
    m.hold_pause(rnd());
    check_bit("so released in hold", 1'b1, so_oe_n);
    m.hold_resume();
    m.xfer(rnd(), rx);
    check_byte("read after hold", d[1] ^ 8'hFF, rx);
    m.select(1'b0);
    $display("test hold done");
    frame_cmd(`OP_SAVE);
    check_bit("save refused", 1'b0, ready_busy);
    frame_cmd(`SET_WRITE_ENABLE_CMD);
    frame_cmd(`OP_SAVE);
    check_bit("save busy", 1'b1, ready_busy);
    check_bit("save pin", 1'b0, hw_store_busy_pin_n);
    check_bit("latch after save", 1'b0, write_enable);
    start_cmd(`OP_READ, 17'h17FFE);
    m.xfer(rnd(), rx);
    check_bit("read refused busy", 1'b1, so_oe_n);
    m.select(1'b0);
    wait_idle();
    frame_cmd(`SET_WRITE_ENABLE_CMD);
    frame_cmd(`OP_RECALL);
    check_bit("recall busy", 1'b1, ready_busy);
    check_bit("recall pin", 1'b1, hw_store_busy_pin_n);
    wait_idle();
    $display("test save recall done");
    for (int i = 0; i < 2; i++) begin
      frame_cmd(`SET_WRITE_ENABLE_CMD);
      frame_cmd(i ? `AUTOSAVE_ON_CMD : `AUTOSAVE_OFF_CMD);
      check_bit("autosave setting", i[0], autosave_enable);
      check_bit("autosave busy", 1'b1, ready_busy);
      wait_idle();
    end
    $display("test autosave done");
    give_verdict();
  end
endmodule : tb_spi_nv_sram_command_slave
